// ===== slot_b_regs_pkg.sv
// Register map, field positions and reset values of the slot front-end register bank.
package slot_b_regs_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam logic [7:0] OFF_STATUS = 8'h00;
	localparam logic [7:0] OFF_FIFO_CFG = 8'h06;
	localparam logic [7:0] OFF_SECOND_SLOT_FRONTEND_MODE = 8'h3b;
	localparam logic [7:0] OFF_FIRST_SLOT_GAIN_CONTROL = 8'h42;
	localparam logic [7:0] OFF_SECOND_SLOT_GAIN_CONTROL = 8'h44;
	localparam logic [7:0] OFF_SECOND_SLOT_PATH_SELECT = 8'h45;
	localparam logic [7:0] OFF_PER_CHANNEL_GAIN_SELECT = 8'h55;
	localparam logic [7:0] OFF_FIFO_ACCESS = 8'h5f;
	localparam logic [15:0] RST_FRONTEND_MODE = 16'h22fc;
	localparam logic [15:0] RECOMMENDED_FRONTEND_MODE = 16'h21f4;
	localparam logic [15:0] RST_GAIN_CONTROL = 16'h1c38;
	localparam logic [15:0] RST_PATH_SELECT = 16'hada5;
	localparam logic [15:0] RST_PER_CHANNEL_GAIN = 16'h0000;
	localparam logic [15:0] RST_FIFO_CFG = 16'h0000;
	localparam logic [15:0] PATH_FULL_ANALOG = 16'hada5;
	localparam logic [15:0] PATH_AMP_TO_ADC = 16'hb065;
	localparam int BIT_INDIVIDUAL_GAIN_EN = 6;
	localparam int BIT_FLUSH = 15;
	localparam int BIT_SECOND_SLOT_FLAG = 6;
	localparam int BIT_FIRST_SLOT_FLAG = 5;
	localparam int BIT_FIFO_ACCESS_EN = 0;
	localparam int THRESH_LSB = 8;
	localparam int THRESH_W = 6;
	localparam int FIRST_SLOT_CH2_LSB = 0;
	localparam int SECOND_SLOT_CH2_LSB = 6;
	typedef enum logic [1:0] {
		GAIN_200K = 2'b00,
		GAIN_100K = 2'b01,
		GAIN_50K = 2'b10,
		GAIN_25K = 2'b11
	} gain_sel_t;
endpackage : slot_b_regs_pkg

// ===== slot_b_frontend_and_status_regs.sv
// Front-end configuration and system status register bank with gain and path decode.
`timescale 1ns/1ps
// Notes on behaviour
// - Gain codes 0..3 mean 200k,100k,50k,25k ohm.
// - Individual enable: ch1 low bits, ch2-4 [11:6].
// - Individual disabled: slot gain drives all channels.
// - 0xADA5 full path, 0xB065 bypass, others reserved.
// - Status [15:8] reports FIFO bytes available.
// - Access enable plus write bit15 flushes FIFO.
// - Second-slot flag sticky, write one clears.
// - First-slot flag sticky, write one clears.
// - FIFO interrupt while words exceed threshold.
// - First-slot individual gains from 0x42 and [5:0].
module slot_b_frontend_and_status_regs
	import slot_b_regs_pkg::*;
(
	input wire logic clk_sys, // 200 MHz system clock
	input wire logic rst_b, // Asynchronous active-low reset
	input wire logic reg_wr, // Register write strobe, one cycle
	input wire logic reg_rd, // Register read strobe, one cycle
	input wire logic [ADDR_W-1:0] reg_addr, // Register address
	input wire logic [DATA_W-1:0] reg_wdata, // Write data
	output logic [DATA_W-1:0] reg_rdata, // Read data, valid with reg_rvalid
	output logic reg_rvalid, // Read answer pulse
	input wire logic first_slot_event, // First-slot sample event pulse
	input wire logic second_slot_event, // Second-slot sample event pulse
	input wire logic [7:0] fifo_byte_count, // Bytes stored in the FIFO
	output logic fifo_flush, // Pulse that discards FIFO contents
	output logic fifo_threshold_irq, // FIFO level above threshold
	output logic first_slot_event_flag, // Sticky first-slot flag
	output logic second_slot_event_flag, // Sticky second-slot flag
	output logic [7:0] first_slot_gains, // Slot A gains, ch4..ch1, 2 bits each
	output logic [7:0] second_slot_gains, // Slot B gains, ch4..ch1, 2 bits each
	output logic [15:0] second_slot_frontend_mode, // Slot B front-end mode word
	output logic second_slot_full_path, // Slot B full analog path selected
	output logic second_slot_bypass // Slot B amplifier-to-converter bypass
);
	// All bank state lives in one struct so that one process registers it.
	typedef struct packed {
		logic [15:0] frontend_mode;
		logic [15:0] first_gain_ctl;
		logic [15:0] second_gain_ctl;
		logic [15:0] path_select;
		logic [15:0] per_channel_gain;
		logic [15:0] fifo_cfg;
		logic fifo_access_en;
		logic first_flag;
		logic second_flag;
		logic [15:0] rdata;
		logic rvalid;
		logic flush;
		logic fifo_irq;
		logic [7:0] first_gains;
		logic [7:0] second_gains;
		logic full_path;
		logic bypass;
	} bank_state_t;

	bank_state_t st;
	bank_state_t next_st;
	// Two-stage copy of the reset pin; only its second stage resets the bank.
	logic [1:0] rst_pipe;
	logic rst_sync_b;

	// The release is synchronised so every flop leaves reset on the same edge.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rst_pipe <= 2'b00;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end
	assign rst_sync_b = rst_pipe[1];

	// The read word and the field slices assume 16-bit registers and 8-bit addresses.
	if (DATA_W != 16 || ADDR_W != 8) begin : g_bad_port_width
		$error("slot register bank needs 16-bit data and 8-bit addresses");
	end
	if (THRESH_LSB + THRESH_W > DATA_W) begin : g_bad_threshold_field
		$error("threshold field does not fit the register width");
	end
	if (FIRST_SLOT_CH2_LSB + 6 > DATA_W
		|| SECOND_SLOT_CH2_LSB + 6 > DATA_W) begin : g_bad_gain_field
		$error("per-channel gain fields do not fit the register width");
	end
	// The status read concatenation places the flags by hand; its byte count field covers the flush bit.
	if (BIT_SECOND_SLOT_FLAG != 6 || BIT_FIRST_SLOT_FLAG != 5
		|| BIT_FLUSH != 15) begin : g_bad_status_layout
		$error("status bit positions differ from the fixed read layout");
	end

	// Channel 1 always follows the slot's own field; channels 2 to 4 switch to the
	// per-channel register only while the slot's individual enable is set.
	logic [1:0] first_gain_sel [4];
	logic [1:0] second_gain_sel [4];

	for (genvar ch = 0; ch < 4; ch++) begin : g_channel
		if (ch == 0) begin : g_own_field
			assign first_gain_sel[ch] = st.first_gain_ctl[1:0];
			assign second_gain_sel[ch] = st.second_gain_ctl[1:0];
		end else begin : g_shared_field
			assign first_gain_sel[ch] = st.first_gain_ctl[BIT_INDIVIDUAL_GAIN_EN]
				? st.per_channel_gain[FIRST_SLOT_CH2_LSB + 2 * (ch - 1) +: 2]
				: st.first_gain_ctl[1:0];
			assign second_gain_sel[ch] = st.second_gain_ctl[BIT_INDIVIDUAL_GAIN_EN]
				? st.per_channel_gain[SECOND_SLOT_CH2_LSB + 2 * (ch - 1) +: 2]
				: st.second_gain_ctl[1:0];
		end
	end

	// One process works out the whole next state from the current one and the ports.
	always_comb begin
		next_st = st;
		// Answer and flush are pulses: they fall back unless set again below.
		next_st.rvalid = 1'b0;
		next_st.flush = 1'b0;
		// A status write stores nothing; its set bits only clear flags or ask for a flush.
		if (reg_wr) begin
			case (reg_addr)
				OFF_STATUS: begin
					if (reg_wdata[BIT_FIRST_SLOT_FLAG]) begin
						next_st.first_flag = 1'b0;
					end
					if (reg_wdata[BIT_SECOND_SLOT_FLAG]) begin
						next_st.second_flag = 1'b0;
					end
					// A flush request without host access enabled is dropped, not queued.
					if (reg_wdata[BIT_FLUSH] && st.fifo_access_en) begin
						next_st.flush = 1'b1;
					end
				end
				OFF_FIFO_CFG: next_st.fifo_cfg = reg_wdata;
				OFF_SECOND_SLOT_FRONTEND_MODE: next_st.frontend_mode = reg_wdata;
				OFF_FIRST_SLOT_GAIN_CONTROL: next_st.first_gain_ctl = reg_wdata;
				OFF_SECOND_SLOT_GAIN_CONTROL: next_st.second_gain_ctl = reg_wdata;
				OFF_SECOND_SLOT_PATH_SELECT: next_st.path_select = reg_wdata;
				OFF_PER_CHANNEL_GAIN_SELECT: next_st.per_channel_gain = reg_wdata;
				// Only one bit of the access register is kept; the rest read back as zero.
				OFF_FIFO_ACCESS: next_st.fifo_access_en = reg_wdata[BIT_FIFO_ACCESS_EN];
				default: begin
				end
			endcase
		end
		// Events are applied after the clear so a simultaneous event is never lost.
		if (first_slot_event) begin
			next_st.first_flag = 1'b1;
		end
		if (second_slot_event) begin
			next_st.second_flag = 1'b1;
		end
		// Read data is captured in the state, so it stands until the next read.
		if (reg_rd) begin
			next_st.rvalid = 1'b1;
			// The byte count is reported as it stands at the read edge, not latched earlier.
			case (reg_addr)
				OFF_STATUS: next_st.rdata = {fifo_byte_count, 1'b0, st.second_flag,
					st.first_flag, 5'b0_0000};
				OFF_FIFO_CFG: next_st.rdata = st.fifo_cfg;
				OFF_SECOND_SLOT_FRONTEND_MODE: next_st.rdata = st.frontend_mode;
				OFF_FIRST_SLOT_GAIN_CONTROL: next_st.rdata = st.first_gain_ctl;
				OFF_SECOND_SLOT_GAIN_CONTROL: next_st.rdata = st.second_gain_ctl;
				OFF_SECOND_SLOT_PATH_SELECT: next_st.rdata = st.path_select;
				OFF_PER_CHANNEL_GAIN_SELECT: next_st.rdata = st.per_channel_gain;
				OFF_FIFO_ACCESS: next_st.rdata = {15'h0000, st.fifo_access_en};
				default: next_st.rdata = 16'h0000;
			endcase
		end
		// Byte count halves to words; the threshold is in two-byte words.
		next_st.fifo_irq = ({1'b0, fifo_byte_count[7:1]}
			> {2'b00, st.fifo_cfg[THRESH_LSB +: THRESH_W]});
		// Registering the selected codes keeps every gain output straight from a flop.
		next_st.first_gains = {first_gain_sel[3], first_gain_sel[2],
			first_gain_sel[1], first_gain_sel[0]};
		next_st.second_gains = {second_gain_sel[3], second_gain_sel[2],
			second_gain_sel[1], second_gain_sel[0]};
		// Reserved path codes select neither mode rather than guess one.
		next_st.full_path = (st.path_select == PATH_FULL_ANALOG);
		next_st.bypass = (st.path_select == PATH_AMP_TO_ADC);
	end

	// Reset values live in the package so every reader of the map sees the same ones.
	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			st.frontend_mode <= RST_FRONTEND_MODE;
			st.first_gain_ctl <= RST_GAIN_CONTROL;
			st.second_gain_ctl <= RST_GAIN_CONTROL;
			st.path_select <= RST_PATH_SELECT;
			st.per_channel_gain <= RST_PER_CHANNEL_GAIN;
			st.fifo_cfg <= RST_FIFO_CFG;
			st.fifo_access_en <= 1'b0;
			st.first_flag <= 1'b0;
			st.second_flag <= 1'b0;
			st.rdata <= 16'h0000;
			st.rvalid <= 1'b0;
			st.flush <= 1'b0;
			st.fifo_irq <= 1'b0;
			st.first_gains <= 8'h00;
			st.second_gains <= 8'h00;
			// The reset path code is the full analog path, so the decode starts there too.
			st.full_path <= 1'b1;
			st.bypass <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// Every output is a field of the registered state; no logic sits after the flops.
	assign reg_rdata = st.rdata;
	assign reg_rvalid = st.rvalid;
	assign fifo_flush = st.flush;
	assign fifo_threshold_irq = st.fifo_irq;
	assign first_slot_event_flag = st.first_flag;
	assign second_slot_event_flag = st.second_flag;
	assign first_slot_gains = st.first_gains;
	assign second_slot_gains = st.second_gains;
	assign second_slot_frontend_mode = st.frontend_mode;
	assign second_slot_full_path = st.full_path;
	assign second_slot_bypass = st.bypass;
endmodule : slot_b_frontend_and_status_regs

// ===== slot_b_regs_props.sv
// Port checks for the slot front-end register bank.
`timescale 1ns/1ps
module slot_b_regs_props
	import slot_b_regs_pkg::*;
(
	input wire logic clk_sys, // Clock
	input wire logic rst_b, // Reset
	input wire logic reg_wr, // Write
	input wire logic [ADDR_W-1:0] reg_addr, // Address
	input wire logic [DATA_W-1:0] reg_wdata, // Data
	input wire logic first_slot_event, // Event A
	input wire logic second_slot_event, // Event B
	input wire logic [7:0] fifo_byte_count, // Bytes
	input wire logic fifo_flush, // Flush
	input wire logic fifo_threshold_irq, // Irq
	input wire logic first_slot_event_flag, // Flag A
	input wire logic second_slot_event_flag, // Flag B
	input wire logic [7:0] second_slot_gains // Gains B
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	wire st_wr = reg_wr && reg_addr == OFF_STATUS;
	wire fl_wr = st_wr && reg_wdata[BIT_FLUSH];
	logic [1:0] g_q;
	always_ff @(posedge clk_sys)
		if (reg_wr) g_q <= reg_wdata[1:0];
	flag_b_set_a:
	assert property (second_slot_event |=> second_slot_event_flag) else $error("flag B not set");
	flag_a_set_a:
	assert property (first_slot_event |=> first_slot_event_flag) else $error("flag A not set");
	flag_b_clear_a:
	assert property (st_wr && reg_wdata[6] && !second_slot_event |=> !second_slot_event_flag)
		else $error("flag B not cleared");
	flag_a_clear_a:
	assert property (st_wr && reg_wdata[5] && !first_slot_event |=> !first_slot_event_flag)
		else $error("flag A not cleared");
	flag_a_hold_a:
	assert property (first_slot_event_flag && !(st_wr && reg_wdata[5]) |=> first_slot_event_flag)
		else $error("flag A lost");
	flush_cause_a:
	assert property (fifo_flush |-> $past(fl_wr)) else $error("flush without request");
	irq_empty_a:
	assert property (fifo_byte_count < 8'h02 |=> !fifo_threshold_irq) else $error("irq when empty");
	gain_all_a:
	assert property (reg_wr && reg_addr == OFF_SECOND_SLOT_GAIN_CONTROL && !reg_wdata[6]
		|-> ##2 second_slot_gains == {4{g_q}}) else $error("shared gain wrong");
endmodule : slot_b_regs_props
bind slot_b_frontend_and_status_regs slot_b_regs_props u_props (
	.clk_sys(clk_sys),
	.rst_b(rst_b),
	.reg_wr(reg_wr),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.first_slot_event(first_slot_event),
	.second_slot_event(second_slot_event),
	.fifo_byte_count(fifo_byte_count),
	.fifo_flush(fifo_flush),
	.fifo_threshold_irq(fifo_threshold_irq),
	.first_slot_event_flag(first_slot_event_flag),
	.second_slot_event_flag(second_slot_event_flag),
	.second_slot_gains(second_slot_gains)
);

// ===== host_model.sv
// Host model driving the register port in place of the serial control master.
`timescale 1ns/1ps
module host_model
	import slot_b_regs_pkg::*;
(
	input wire logic clk_sys, // Clock
	output logic reg_wr = 1'b0, // Write strobe
	output logic reg_rd = 1'b0, // Read strobe
	output logic [ADDR_W-1:0] reg_addr = 8'h00, // Address
	output logic [DATA_W-1:0] reg_wdata = 16'h0000, // Write data
	input wire logic [DATA_W-1:0] reg_rdata, // Read data
	input wire logic reg_rvalid // Read answer
);
	task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
		output logic [15:0] q);
		@(posedge clk_sys) #1;
		reg_wr = w;
		reg_rd = !w;
		reg_addr = a;
		reg_wdata = d;
		@(posedge clk_sys) #1;
		q = reg_rvalid ? reg_rdata : 16'hxxxx;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		// Idle lines carry the inverse so stale values never pass for live ones.
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask : xfer
endmodule : host_model

// ===== test_slot_b_frontend_and_status_regs.sv
// Self-checking bench for the slot front-end register bank.
`timescale 1ns/1ps
module test_slot_b_frontend_and_status_regs import slot_b_regs_pkg::*;;
	logic clk_sys = 0, rst_b = 0, reg_wr, reg_rd, reg_rvalid, fifo_flush, fifo_threshold_irq;
	logic first_slot_event = 0, second_slot_event = 0, first_slot_event_flag;
	logic second_slot_event_flag, second_slot_full_path, second_slot_bypass;
	logic [7:0] reg_addr, fifo_byte_count = 0, first_slot_gains, second_slot_gains;
	logic [15:0] reg_wdata, reg_rdata, second_slot_frontend_mode, q;
	int miscompares = 0, num_checks = 0;
	wire [15:0] gain_v = {first_slot_gains, second_slot_gains};
	wire [15:0] path_v = {14'h0000, second_slot_full_path, second_slot_bypass};
	always #2.5 clk_sys = ~clk_sys;
	slot_b_frontend_and_status_regs u_dut (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid),
		.first_slot_event(first_slot_event),
		.second_slot_event(second_slot_event),
		.fifo_byte_count(fifo_byte_count),
		.fifo_flush(fifo_flush),
		.fifo_threshold_irq(fifo_threshold_irq),
		.first_slot_event_flag(first_slot_event_flag),
		.second_slot_event_flag(second_slot_event_flag),
		.first_slot_gains(first_slot_gains),
		.second_slot_gains(second_slot_gains),
		.second_slot_frontend_mode(second_slot_frontend_mode),
		.second_slot_full_path(second_slot_full_path),
		.second_slot_bypass(second_slot_bypass)
	);
	host_model u_host (
		.clk_sys(clk_sys),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid)
	);
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		u_host.xfer(1'b1, a, d, q);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		u_host.xfer(1'b0, a, 16'h0000, q);
		chk(q, e);
	endtask : rd
	// Derived outputs follow a write by two edges.
	task automatic settle;
		repeat (2) @(posedge clk_sys);
		#1;
	endtask : settle
	task automatic t_config;
		logic [15:0] pw[3] = '{PATH_AMP_TO_ADC, 16'h1234, PATH_FULL_ANALOG};
		logic [15:0] pe[3] = '{16'h0001, 16'h0000, 16'h0002};
		rd(OFF_SECOND_SLOT_FRONTEND_MODE, 16'h22fc);
		rd(OFF_SECOND_SLOT_PATH_SELECT, 16'hada5);
		rd(8'h7e, 16'h0000);
		wr(OFF_SECOND_SLOT_FRONTEND_MODE, RECOMMENDED_FRONTEND_MODE);
		chk(second_slot_frontend_mode, 16'h21f4);
		wr(OFF_PER_CHANNEL_GAIN_SELECT, 16'h0e76);
		wr(OFF_SECOND_SLOT_GAIN_CONTROL, 16'h1c3b);
		settle;
		chk(gain_v, 16'h00ff);
		wr(OFF_SECOND_SLOT_GAIN_CONTROL, 16'h1c40);
		wr(OFF_FIRST_SLOT_GAIN_CONTROL, 16'h1c41);
		settle;
		chk(gain_v, 16'hd9e4);
		for (int i = 0; i < 3; i++) begin
			wr(OFF_SECOND_SLOT_PATH_SELECT, pw[i]);
			settle;
			chk(path_v, pe[i]);
		end
	endtask : t_config
	task automatic t_status;
		fifo_byte_count = 8'h2a;
		rd(OFF_STATUS, 16'h2a00);
		wr(OFF_FIFO_CFG, 16'h1400);
		settle;
		chk(16'(fifo_threshold_irq), 16'h0001);
		fifo_byte_count = 8'h28;
		settle;
		chk(16'(fifo_threshold_irq), 16'h0000);
		fork
			wr(OFF_STATUS, 16'h0040);
			begin
				@(posedge clk_sys) #1 second_slot_event = 1;
				@(posedge clk_sys) #1 second_slot_event = 0;
			end
		join
		rd(OFF_STATUS, 16'h2840);
		wr(OFF_STATUS, 16'h0040);
		first_slot_event = 1;
		@(posedge clk_sys) #1 first_slot_event = 0;
		rd(OFF_STATUS, 16'h2820);
		wr(OFF_STATUS, 16'h0020);
		rd(OFF_STATUS, 16'h2800);
		wr(OFF_STATUS, 16'h8000);
		chk(16'(fifo_flush), 16'h0000);
		wr(OFF_FIFO_ACCESS, 16'h0001);
		wr(OFF_STATUS, 16'h8000);
		chk(16'(fifo_flush), 16'h0001);
	endtask : t_status
	task automatic print_verdict;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (20) @(posedge clk_sys);
		#1 rst_b = 1;
		repeat (3) @(posedge clk_sys);
		t_config;
		t_status;
		print_verdict;
	end
	initial begin
		repeat (5000) @(posedge clk_sys);
		miscompares++;
		print_verdict;
	end
endmodule : test_slot_b_frontend_and_status_regs
